// >>> src/mrx_pkg.sv
// Shared constants and types for the MII receive and management block
package mrx_pkg;
    // Receive path word layout: {end marker, error, nibble}
    localparam int NIB_W        = 4;
    localparam int WORD_W       = 6;
    localparam int WORD_EOF_BIT = 5;
    localparam int WORD_ERR_BIT = 4;
    localparam int FIFO_DEPTH   = 8;

    // Management clock timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int MDC_MIN_PHASE_NS  = 160;
    localparam int MDC_MIN_PERIOD_NS = 400;
    localparam int MDC_PHASE_CYC =
        (MDC_MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MDC_PERIOD_HALF_CYC =
        (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int MDC_HALF_CYC =
        (MDC_PHASE_CYC > MDC_PERIOD_HALF_CYC) ? MDC_PHASE_CYC
                                              : MDC_PERIOD_HALF_CYC;

    // Management frame layout, most significant bit sent first
    localparam int          MGMT_FRAME_BITS = 64;
    localparam logic [5:0]  MGMT_LAST_BIT   = 6'h3f;
    localparam logic [5:0]  MGMT_TA_BIT     = 6'h2e;
    localparam logic [5:0]  MGMT_DATA_BIT   = 6'h30;
    localparam logic [31:0] MGMT_PREAMBLE   = 32'hffffffff;
    localparam logic [1:0]  MGMT_START      = 2'h1;
    localparam logic [1:0]  MGMT_OP_READ    = 2'h2;
    localparam logic [1:0]  MGMT_OP_WRITE   = 2'h1;
    localparam logic [1:0]  MGMT_TA_WRITE   = 2'h2;
    localparam logic [1:0]  MGMT_TA_READ    = 2'h3;

    // Management sequencer states
    typedef enum logic [2:0] {
        MRX_ST_IDLE = 3'b001,
        MRX_ST_XFER = 3'b010,
        MRX_ST_DONE = 3'b100
    } mrx_mgmt_state_t;
endpackage : mrx_pkg

// >>> src/mrx_fifo.sv
// Dual-clock FIFO with gray pointers and a registered read port
`timescale 1ns/1ps
module mrx_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 8
) (
    input  wire logic             wr_clk,    // Filling side clock
    input  wire logic             wr_rst_b,  // Filling side reset
    input  wire logic             wr_valid,  // Word offered
    output logic                  wr_ready,  // Room for a word
    input  wire logic [WIDTH-1:0] wr_data,   // Word written
    input  wire logic             rd_clk,    // Draining side clock
    input  wire logic             rd_rst_b,  // Draining side reset
    output logic                  rd_valid,  // Output word held
    input  wire logic             rd_ready,  // Output word taken
    output logic      [WIDTH-1:0] rd_data    // Output word
);
    localparam int AW = $clog2(DEPTH);

    // Binary to gray, used for both pointers
    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wbin;
    logic [AW:0]      wgray;
    logic [AW:0]      rbin;
    logic [AW:0]      rgray;
    logic [AW:0]      rq1;
    logic [AW:0]      rq2;
    logic [AW:0]      wq1;
    logic [AW:0]      wq2;
    logic             wr_fire;
    logic             rd_load;
    logic             empty;

    // Full when write pointer is one lap ahead of the read pointer
    assign wr_ready = (wgray != {~rq2[AW:AW-1], rq2[AW-2:0]});
    assign wr_fire  = wr_valid & wr_ready;
    assign empty    = (rgray == wq2);
    assign rd_load  = ~empty & (~rd_valid | rd_ready);

    // Write pointer and storage
    always_ff @(posedge wr_clk or negedge wr_rst_b)
        if (!wr_rst_b)
        begin
            wbin  <= '0;
            wgray <= '0;
        end
        else if (wr_fire)
        begin
            wbin  <= wbin + 1'b1;
            wgray <= to_gray(wbin + 1'b1);
        end

    always_ff @(posedge wr_clk)
        if (wr_fire)
            mem[wbin[AW-1:0]] <= wr_data;

    // Read pointer crosses into the write domain
    always_ff @(posedge wr_clk or negedge wr_rst_b)
        if (!wr_rst_b)
        begin
            rq1 <= '0;
            rq2 <= '0;
        end
        else
        begin
            rq1 <= rgray;
            rq2 <= rq1;
        end

    // Write pointer crosses into the read domain
    always_ff @(posedge rd_clk or negedge rd_rst_b)
        if (!rd_rst_b)
        begin
            wq1 <= '0;
            wq2 <= '0;
        end
        else
        begin
            wq1 <= wgray;
            wq2 <= wq1;
        end

    // Read pointer and output register
    always_ff @(posedge rd_clk or negedge rd_rst_b)
        if (!rd_rst_b)
        begin
            rbin     <= '0;
            rgray    <= '0;
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end
        else if (rd_load)
        begin
            rbin     <= rbin + 1'b1;
            rgray    <= to_gray(rbin + 1'b1);
            rd_valid <= 1'b1;
            rd_data  <= mem[rbin[AW-1:0]];
        end
        else if (rd_ready)
            rd_valid <= 1'b0;
endmodule : mrx_fifo

// >>> src/mrx_top.sv
// MII receive path, medium status and management port of the MAC
//
// Overview of operation
// [R1] PHY supplies 25 or 2.5 MHz receive clock
// [R2] Serial coder mode receive clock is 10 MHz
// [R3] Data valid high throughout each frame
// [R4] Data valid drops before edge after last
// [R5] Capture nibble only while data valid high
// [R6] Error counts only while data valid high
// [R7] Error input held low in serial mode
// [R8] Carrier high while either medium busy
// [R9] Carrier sense is asynchronous, synchronised first
// [R10] Collision high for whole collision
// [R11] Collision is asynchronous, synchronised first
// [R12] Full duplex ignores collision input
// [R13] Management clock phases at least 160 ns
// [R14] Management clock period at least 400 ns
// [R15] PHY drives read data on management clock
// [R16] Write data driven on management clock
// [R17] Receive words cross clocks through FIFO
// [R18] Standard management frame, released for turnaround
`timescale 1ns/1ps
module mrx_top #(
    parameter int FIFO_DEPTH = mrx_pkg::FIFO_DEPTH
) (
    input  wire logic        core_clk,       // System clock, 20 MHz
    input  wire logic        rst_b,          // Async reset, active low
    input  wire logic        rx_clk,         // Receive clock from PHY
    input  wire logic [3:0]  rxd,            // Receive nibble pins
    input  wire logic        rx_dv,          // Receive data valid pin
    input  wire logic        rx_er,          // Receive error pin
    input  wire logic        crs,            // Carrier sense pin
    input  wire logic        col,            // Collision pin
    input  wire logic        full_duplex,    // Duplex setting
    output logic [3:0]       rx_nib,         // Received nibble
    output logic             rx_nib_err,     // Nibble or frame errored
    output logic             rx_eof,         // End of frame marker
    output logic             rx_valid,       // Word on rx outputs
    input  wire logic        rx_ready,       // Word consumed
    output logic             carrier,        // Synced carrier sense
    output logic             collision,      // Synced, duplex gated
    input  wire logic        mgmt_start,     // Start transfer pulse
    input  wire logic        mgmt_read,      // Transfer is a read
    input  wire logic [4:0]  mgmt_phy_addr,  // PHY address
    input  wire logic [4:0]  mgmt_reg_addr,  // PHY register address
    input  wire logic [15:0] mgmt_wdata,     // Write data
    output logic [15:0]      mgmt_rdata,     // Read data
    output logic             mgmt_busy,      // Transfer under way
    output logic             mgmt_done,      // Transfer finished pulse
    output logic             mdc,            // Management clock pin
    input  wire logic        mdio_in,        // Management data in
    output logic             mdio_out,       // Management data out
    output logic             mdio_oe         // Management data enable
);
    localparam int          HALF     = mrx_pkg::MDC_HALF_CYC;
    localparam logic [3:0]  PH_RISE  = 4'(HALF);
    localparam logic [3:0]  PH_LAST  = 4'(2 * HALF - 1);
    localparam int          WW       = mrx_pkg::WORD_W;

    // Receive clock domain
    logic          rx_rst_s1;
    logic          rx_rst_b;
    logic [3:0]    nib_q;
    logic          dv_q;
    logic          er_q;
    logic          in_frame;
    logic          eof_pend;
    logic          err_acc;
    logic          eof_need;
    logic          wr_valid;
    logic          wr_ready;
    logic [WW-1:0] wr_word;

    // Core clock domain
    logic [WW-1:0] rd_word;
    logic          crs_s1;
    logic          crs_s2;
    logic          col_s1;
    logic          col_s2;
    logic          mdio_s1;
    logic          mdio_s2;
    mrx_pkg::mrx_mgmt_state_t state;
    mrx_pkg::mrx_mgmt_state_t next_state;
    logic [3:0]    phase;
    logic [5:0]    bit_idx;
    logic [63:0]   sreg;
    logic          rd_op;
    logic          bit_end;

    // Reset release retimed to the receive clock, assertion stays async
    always_ff @(posedge rx_clk or negedge rst_b)
        if (!rst_b)
        begin
            rx_rst_s1 <= 1'b0;
            rx_rst_b  <= 1'b0;
        end
        else
        begin
            rx_rst_s1 <= 1'b1;
            rx_rst_b  <= rx_rst_s1;
        end

    // Pins sampled on the receive clock that times them
    always_ff @(posedge rx_clk or negedge rx_rst_b)
        if (!rx_rst_b)
        begin
            nib_q <= 4'h0;
            dv_q  <= 1'b0;
            er_q  <= 1'b0;
        end
        else
        begin
            nib_q <= rxd;
            dv_q  <= rx_dv;
            er_q  <= rx_er;
        end

    // Frame ends on the first edge that finds data valid low
    assign eof_need = (in_frame & ~dv_q) | eof_pend;   // [R4]
    assign wr_valid = eof_need | dv_q;                 // [R5]

    // End marker carries the frame error; data words carry nibble error
    always_comb
    begin
        wr_word = '0;
        if (eof_need)
        begin
            wr_word[mrx_pkg::WORD_EOF_BIT] = 1'b1;
            wr_word[mrx_pkg::WORD_ERR_BIT] = err_acc;
        end
        else
        begin
            wr_word[mrx_pkg::WORD_ERR_BIT] = er_q & dv_q;   // [R6]
            wr_word[3:0]                   = nib_q;         // [R5]
        end
    end

    // Frame tracking in the receive domain
    always_ff @(posedge rx_clk or negedge rx_rst_b)
        if (!rx_rst_b)
            in_frame <= 1'b0;
        else
            in_frame <= dv_q;   // [R3]

    // The PHY cannot be stalled: a full FIFO drops the nibble and
    // taints the frame, and an end marker waits until room appears
    always_ff @(posedge rx_clk or negedge rx_rst_b)
        if (!rx_rst_b)
        begin
            eof_pend <= 1'b0;
            err_acc  <= 1'b0;
        end
        else if (eof_need)
        begin
            eof_pend <= ~wr_ready;
            if (wr_ready)
                err_acc <= dv_q;
            else if (dv_q)
                err_acc <= 1'b1;
        end
        else if (dv_q & (er_q | ~wr_ready))
            err_acc <= 1'b1;   // [R6]

    // Receive words cross to the core clock through the FIFO
    mrx_fifo #(
        .WIDTH (WW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (                  // [R17]
        .wr_clk   (rx_clk),
        .wr_rst_b (rx_rst_b),
        .wr_valid (wr_valid),
        .wr_ready (wr_ready),
        .wr_data  (wr_word),
        .rd_clk   (core_clk),
        .rd_rst_b (rst_b),
        .rd_valid (rx_valid),
        .rd_ready (rx_ready),
        .rd_data  (rd_word)
    );

    // Output fields come straight from the FIFO output register
    assign rx_nib     = rd_word[3:0];
    assign rx_nib_err = rd_word[mrx_pkg::WORD_ERR_BIT];
    assign rx_eof     = rd_word[mrx_pkg::WORD_EOF_BIT];

    // Medium status pins change with no relation to any clock here
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            crs_s1 <= 1'b0;
            crs_s2 <= 1'b0;
            col_s1 <= 1'b0;
            col_s2 <= 1'b0;
        end
        else
        begin
            crs_s1 <= crs;      // [R9]
            crs_s2 <= crs_s1;   // [R9]
            col_s1 <= col;      // [R11]
            col_s2 <= col_s1;   // [R11]
        end

    // Status outputs, collision masked in full duplex
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            carrier   <= 1'b0;
            collision <= 1'b0;
        end
        else
        begin
            carrier   <= crs_s2;                  // [R9]
            collision <= col_s2 & ~full_duplex;   // [R11] [R12]
        end

    // Management data input comes from the pin, so synchronise it
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            mdio_s1 <= 1'b0;
            mdio_s2 <= 1'b0;
        end
        else
        begin
            mdio_s1 <= mdio_in;
            mdio_s2 <= mdio_s1;
        end

    // One bit is two phases of HALF core clocks each
    assign bit_end = (phase == PH_LAST);

    // Sequencer next state
    always_comb
    begin
        next_state = state;
        case (state)
            mrx_pkg::MRX_ST_IDLE:
                if (mgmt_start)
                    next_state = mrx_pkg::MRX_ST_XFER;
            mrx_pkg::MRX_ST_XFER:
                if (bit_end && bit_idx == mrx_pkg::MGMT_LAST_BIT)
                    next_state = mrx_pkg::MRX_ST_DONE;
            mrx_pkg::MRX_ST_DONE:
                next_state = mrx_pkg::MRX_ST_IDLE;
            default:
                next_state = mrx_pkg::MRX_ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            state <= mrx_pkg::MRX_ST_IDLE;
        else
            state <= next_state;

    // Phase and bit counters; divider runs off the core clock only
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            phase   <= 4'h0;
            bit_idx <= 6'h00;
        end
        else if (state != mrx_pkg::MRX_ST_XFER)
        begin
            phase   <= 4'h0;
            bit_idx <= 6'h00;
        end
        else if (bit_end)
        begin
            phase   <= 4'h0;            // [R14]
            bit_idx <= bit_idx + 6'h01;
        end
        else
            phase <= phase + 4'h1;      // [R13]

    // Frame image loaded at start, shifted out one bit per period
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            sreg  <= 64'h0;
            rd_op <= 1'b0;
        end
        else if (state == mrx_pkg::MRX_ST_IDLE && mgmt_start)
        begin
            rd_op <= mgmt_read;
            sreg  <= {mrx_pkg::MGMT_PREAMBLE, mrx_pkg::MGMT_START,
                      mgmt_read ? mrx_pkg::MGMT_OP_READ
                                : mrx_pkg::MGMT_OP_WRITE,
                      mgmt_phy_addr, mgmt_reg_addr,
                      mgmt_read ? mrx_pkg::MGMT_TA_READ
                                : mrx_pkg::MGMT_TA_WRITE,
                      mgmt_wdata};      // [R18]
        end
        else if (state == mrx_pkg::MRX_ST_XFER && phase == 4'h0)
            sreg <= {sreg[62:0], 1'b0};

    // Clock pin: low for HALF cycles then high for HALF cycles
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            mdc <= 1'b0;
        else if (state != mrx_pkg::MRX_ST_XFER)
            mdc <= 1'b0;
        else if (phase == 4'h0)
            mdc <= 1'b0;                // [R13]
        else if (phase == PH_RISE)
            mdc <= 1'b1;                // [R13] [R14]

    // Data changes with the falling edge so it is settled at rising;
    // line is released from the read turnaround onward
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end
        else if (state != mrx_pkg::MRX_ST_XFER)
        begin
            mdio_out <= 1'b0;
            mdio_oe  <= 1'b0;
        end
        else if (phase == 4'h0)
        begin
            mdio_out <= sreg[63];                                  // [R16]
            mdio_oe  <= ~(rd_op && bit_idx >= mrx_pkg::MGMT_TA_BIT); // [R18]
        end

    // Read data taken as the clock rises; synchroniser lag is well
    // inside the low phase, so the PHY's output delay still fits
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
            mgmt_rdata <= 16'h0000;
        else if (state == mrx_pkg::MRX_ST_XFER && phase == PH_RISE &&
                 rd_op && bit_idx >= mrx_pkg::MGMT_DATA_BIT)
            mgmt_rdata <= {mgmt_rdata[14:0], mdio_s2};   // [R18]

    // Busy and completion flags
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b)
        begin
            mgmt_busy <= 1'b0;
            mgmt_done <= 1'b0;
        end
        else
        begin
            mgmt_busy <= (next_state != mrx_pkg::MRX_ST_IDLE);
            mgmt_done <= (next_state == mrx_pkg::MRX_ST_DONE);
        end
endmodule : mrx_top

// >>> verif/mrx_chk_properties.sv
// Assertions on the core-side ports of the MII receive block
`timescale 1ns/1ps
module mrx_chk #(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic       core_clk,    // System clock
    input wire logic       rst_b,       // Async reset
    input wire logic       crs,         // Carrier pin
    input wire logic       col,         // Collision pin
    input wire logic       full_duplex, // Duplex setting
    input wire logic [3:0] rx_nib,      // Output nibble
    input wire logic       rx_nib_err,  // Output error
    input wire logic       rx_eof,      // Output end marker
    input wire logic       rx_valid,    // Output word held
    input wire logic       rx_ready,    // Word taken
    input wire logic       carrier,     // Synced carrier
    input wire logic       collision,   // Synced collision
    input wire logic       mgmt_start,  // Transfer request
    input wire logic       mgmt_busy,   // Transfer running
    input wire logic       mgmt_done,   // Transfer end pulse
    input wire logic       mdc,         // Management clock
    input wire logic       mdio_out,    // Line drive value
    input wire logic       mdio_oe      // Line drive enable
);
    int busy_cnt;  // Samples of the running transfer

    // Transfer length, cleared whenever the engine is idle
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            busy_cnt <= 0;
        else
            busy_cnt <= mgmt_busy ? busy_cnt + 1 : 0;
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // Async pins reach the outputs three edges later, never sooner
    AST_CARRIER_SYNC: assert property ($past(rst_b, 3) |->
        carrier == $past(crs, 3)) else $error("carrier not crs delayed");
    AST_COLLISION_SYNC: assert property (
        (!full_duplex)[*4] ##0 $past(rst_b, 3) |->
        collision == $past(col, 3)) else $error("collision not col delayed");
    AST_DUPLEX_MASK: assert property (
        full_duplex[*4] |-> !collision) else $error("collision in full duplex");
    // Each phase is four core cycles, so 200 ns and a 400 ns period
    AST_MDC_HIGH: assert property (
        $rose(mdc) |-> mdc[*4] ##1 !mdc) else $error("mdc high phase length");
    AST_MDC_LOW: assert property ($fell(mdc) && mgmt_busy |->
        (!mdc)[*4] ##1 mdc) else $error("mdc low phase length");
    AST_MDIO_CHANGE: assert property (
        mdio_oe && $changed(mdio_out) |-> !mdc) else $error("mdio moved on high");
    AST_DONE_LATENCY: assert property (
        mgmt_start && !mgmt_busy && !mgmt_done |-> ##[513:516] $rose(mgmt_done))
        else $error("transfer end late or missing");
    AST_DONE_END: assert property ($rose(mgmt_done) |->
        mgmt_busy ##1 (!mgmt_done && !mgmt_busy && !mdc && !mdio_oe))
        else $error("transfer end not clean");
    AST_BUSY_LENGTH: assert property (
        $fell(mgmt_busy) |-> busy_cnt inside {[512:513]})
        else $error("busy span wrong");
    AST_RX_HOLD: assert property (rx_valid && !rx_ready |=>
        rx_valid && $stable({rx_nib, rx_nib_err, rx_eof}))
        else $error("output word dropped before taken");

    CV_DONE: cover property ($rose(mgmt_done));
    CV_FRAME_ERR: cover property (rx_valid && rx_ready && rx_eof && rx_nib_err);
    CV_COLLISION: cover property ($rose(collision));
endmodule : mrx_chk

bind mrx_top mrx_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .core_clk, .rst_b, .crs, .col, .full_duplex, .rx_nib, .rx_nib_err,
    .rx_eof, .rx_valid, .rx_ready, .carrier, .collision, .mgmt_start,
    .mgmt_busy, .mgmt_done, .mdc, .mdio_out, .mdio_oe);

// >>> verif/mrx_phy_model.sv
// Behavioural PHY: receive pins, receive clock and management replies
`timescale 1ns/1ps
module mrx_phy_model (
    output logic       rx_clk,   // Free-running receive clock
    output logic [3:0] rxd,      // Nibble pins
    output logic       rx_dv,    // Data valid
    output logic       rx_er,    // Receive error
    input  wire logic  mdc,      // Management clock
    input  wire logic  mdio_out, // MAC drive value
    input  wire logic  mdio_oe,  // MAC drive enable
    output logic       mdio_in   // Resolved line level
);
    logic [15:0] rd_val;  // Value returned on reads
    logic        phy_oe;
    logic        phy_d;
    int          n_rel;

    // 125 ns clock, offset so it keeps no phase tie to the core
    initial
    begin
        {rxd, rx_dv, rx_er, phy_oe, phy_d} = 8'h00;
        rd_val = 16'h0000;
        n_rel = 0;
        rx_clk = 1'b0;
        #17;
        forever #62.5 rx_clk = ~rx_clk;
    end

    // Pull-up holds the line when nobody drives it
    assign mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_d : 1'b1);

    // Count falls since the MAC let go: TA bit, then 16 data bits
    always @(negedge mdc)
    begin
        #1;
        n_rel = mdio_oe ? 0 : n_rel + 1;
        phy_oe = n_rel >= 2 && n_rel <= 18;
        phy_d = (n_rel >= 3 && n_rel <= 18) ? rd_val[18-n_rel] : 1'b0;
    end

    // One receive period of pins, changed on the falling edge
    task automatic put(input logic [3:0] d, input logic dv,
                       input logic er);
        @(negedge rx_clk);
        rxd = d;
        rx_dv = dv;
        rx_er = er;
    endtask : put
endmodule : mrx_phy_model

// >>> verif/test_mii_receive_phy_interface.sv
// Self-checking bench for the MII receive and management block
`timescale 1ns/1ps
module test_mii_receive_phy_interface;
    logic        core_clk, rst_b, rx_clk, rx_dv, rx_er, crs, col;
    logic        full_duplex, rx_nib_err, rx_eof, rx_valid, rx_ready;
    logic        carrier, collision, mgmt_start, mgmt_read, mgmt_busy;
    logic        mgmt_done, mdc, mdio_in, mdio_out, mdio_oe, stall;
    logic [3:0]  rxd, rx_nib;
    logic [4:0]  mgmt_phy_addr, mgmt_reg_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata;
    logic [63:0] cap;
    logic [6:0]  exp_q[$];
    logic [6:0]  exp_w;
    int          seed = 62;
    int          failures;
    int          total_checks;

    mrx_top #(.FIFO_DEPTH(8)) i_dut (.core_clk, .rst_b, .rx_clk, .rxd,
        .rx_dv, .rx_er, .crs, .col, .full_duplex, .rx_nib, .rx_nib_err,
        .rx_eof, .rx_valid, .rx_ready, .carrier, .collision, .mgmt_start,
        .mgmt_read, .mgmt_phy_addr, .mgmt_reg_addr, .mgmt_wdata,
        .mgmt_rdata, .mgmt_busy, .mgmt_done, .mdc, .mdio_in, .mdio_out,
        .mdio_oe);
    mrx_phy_model i_phy (.rx_clk, .rxd, .rx_dv, .rx_er, .mdc, .mdio_out,
        .mdio_oe, .mdio_in);

    // Core clock, 50 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // Frame on the pins; stray error level in the gap must not count
    task automatic send_frame(input int len, input logic ovf,
                              input logic ser);
        logic [3:0] d;
        logic       e;
        logic       ferr;
        ferr = ovf;
        for (int i = 0; i < len; i++)
        begin
            d = 4'($random(seed));
            e = !ser && ($random(seed) & 7) == 0;
            ferr = ferr | e;
            exp_q.push_back({ovf, 1'b0, e, d});
            i_phy.put(d, 1'b1, e);
        end
        exp_q.push_back({2'b01, ferr, 4'h0});
        repeat (3) i_phy.put(4'($random(seed)), 1'b0, !ser);
    endtask : send_frame

    // Wait, bounded, until every expected word was handed over
    task automatic drain;
        for (int n = 0; n < 3000 && exp_q.size() > 0; n++)
            @(negedge core_clk);
        check("words left", exp_q.size(), 0);
        @(negedge core_clk);
    endtask : drain

    // Transfer with start held while busy and data changed mid-way
    task automatic mgmt_xfer(input logic rd);
        logic [63:0] exp;
        i_phy.rd_val = 16'($random(seed));
        mgmt_read = rd;
        mgmt_phy_addr = 5'($random(seed));
        mgmt_reg_addr = 5'($random(seed));
        mgmt_wdata = 16'($random(seed));
        exp = {mrx_pkg::MGMT_PREAMBLE, mrx_pkg::MGMT_START,
               rd ? mrx_pkg::MGMT_OP_READ : mrx_pkg::MGMT_OP_WRITE,
               mgmt_phy_addr, mgmt_reg_addr, mrx_pkg::MGMT_TA_WRITE,
               mgmt_wdata};
        mgmt_start = 1'b1;
        repeat (20) @(negedge core_clk);
        mgmt_start = 1'b0;
        mgmt_wdata = ~mgmt_wdata;
        for (int n = 0; n < 600 && mgmt_done !== 1'b1; n++)
            @(negedge core_clk);
        check("mgmt frame", cap >> (rd ? 18 : 0), exp >> (rd ? 18 : 0));
        if (rd)
            check("read data", mgmt_rdata, i_phy.rd_val);
        check("done pulse", {mgmt_done, mgmt_busy}, 2'b11);
        @(negedge core_clk);
    endtask : mgmt_xfer

    // Line bits as the PHY samples them
    always @(posedge mdc)
        cap <= {cap[62:0], mdio_out};

    // Consumer stalls at random so words back up in the buffer
    always @(negedge core_clk)
        rx_ready <= !stall && ($random(seed) & 1);

    // Every handed-over word is compared with the model queue
    always @(posedge core_clk)
    begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1)
        begin
            while (rx_eof === 1'b1 && exp_q.size() > 0 && exp_q[0][6])
                void'(exp_q.pop_front());
            exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 7'h3f;
            check("rx word", {rx_eof, rx_nib_err, rx_nib}, exp_w[5:0]);
        end
    end

    initial
    begin
        #400000;
        failures++;
        $display("watchdog expired");
        complete_run;
    end

    initial
    begin
        {rst_b, stall, crs, col, full_duplex} = 5'h00;
        {mgmt_start, mgmt_read, mgmt_phy_addr, mgmt_reg_addr} = 12'h000;
        mgmt_wdata = 16'h0000;
        repeat (3) @(negedge core_clk);
        rst_b = 1'b1;
        @(negedge core_clk);
        check("idle outputs", {rx_valid, mgmt_busy, mdc, mdio_oe}, 4'h0);
        repeat (12) @(posedge rx_clk);
        for (int f = 0; f < 6; f++)
            send_frame(1 + ($random(seed) & 7), 1'b0, f == 5);
        drain();
        $display("test frames done");
        stall = 1'b1;
        send_frame(14, 1'b1, 1'b0);
        repeat (30) @(negedge core_clk);
        stall = 1'b0;
        drain();
        $display("test overflow done");
        for (int i = 0; i < 8; i++)
        begin
            {full_duplex, col, crs} = 3'(i);
            crs = crs | col;
            repeat (5) @(negedge core_clk);
            check("carrier", carrier, crs);
            check("collision", collision, col & ~full_duplex);
        end
        $display("test status done");
        mgmt_xfer(1'b0);
        mgmt_xfer(1'b1);
        $display("test management done");
        complete_run;
    end
endmodule : test_mii_receive_phy_interface
